//--- shared/cbe_pkg.sv
// Package for the conditional branch evaluator: opcodes, flag positions,
// cycle counts and state codes.
// Assumes the core presents one fetched instruction at a time.
package cbe_pkg;
    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] OP_BRANCH_HALFCARRY_CLEAR = 8'h28;
    localparam logic [7:0] OP_BRANCH_HALFCARRY_SET = 8'h29;
    localparam logic [7:0] OP_BRANCH_UNSIGNED_GREATER = 8'h22;
    localparam logic [7:0] OP_BRANCH_UNSIGNED_LE = 8'h23;
    localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h24;
    localparam logic [7:0] OP_BRANCH_CARRY_SET = 8'h25;
    localparam logic [7:0] OP_BRANCH_NONZERO = 8'h26;
    localparam logic [7:0] OP_BRANCH_NEGATIVE = 8'h2B;
    localparam logic [7:0] OP_BRANCH_MASK_CLEAR = 8'h2C;
    localparam logic [7:0] OP_BRANCH_MASK_SET = 8'h2D;
    localparam logic [7:0] OP_BRANCH_IRQ_PIN_LOW = 8'h2E;
    localparam logic [7:0] OP_BRANCH_IRQ_PIN_HIGH = 8'h2F;
    localparam logic [7:0] OP_BITTEST_IMM = 8'hA5;
    localparam logic [7:0] OP_BITTEST_DIR = 8'hB5;
    localparam logic [7:0] OP_BITTEST_EXT = 8'hC5;
    localparam logic [7:0] OP_BITTEST_IX2 = 8'hD5;
    localparam logic [7:0] OP_BITTEST_IX1 = 8'hE5;
    localparam logic [7:0] OP_BITTEST_IX0 = 8'hF5;
    // ************************************************************
    // Condition code bit positions: H I N Z C
    // ************************************************************
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    localparam logic [4:0] CC_RESET = 5'h08;
    // ************************************************************
    // Lengths and cycle counts
    // ************************************************************
    localparam logic [15:0] BRANCH_LEN = 16'h0002;
    localparam logic [3:0] CYC_BR_HMOS = 4'h4;
    localparam logic [3:0] CYC_BR_CMOS = 4'h3;
    // Bit test: imm, dir, ext, ix0, ix1, ix2
    localparam logic [3:0] CYC_BT_HMOS_IMM = 4'h2;
    localparam logic [3:0] CYC_BT_HMOS_DIR = 4'h4;
    localparam logic [3:0] CYC_BT_HMOS_EXT = 4'h5;
    localparam logic [3:0] CYC_BT_HMOS_IX0 = 4'h4;
    localparam logic [3:0] CYC_BT_HMOS_IX1 = 4'h5;
    localparam logic [3:0] CYC_BT_HMOS_IX2 = 4'h6;
    localparam logic [3:0] CYC_BT_CMOS_IMM = 4'h2;
    localparam logic [3:0] CYC_BT_CMOS_DIR = 4'h3;
    localparam logic [3:0] CYC_BT_CMOS_EXT = 4'h4;
    localparam logic [3:0] CYC_BT_CMOS_IX0 = 4'h3;
    localparam logic [3:0] CYC_BT_CMOS_IX1 = 4'h4;
    localparam logic [3:0] CYC_BT_CMOS_IX2 = 4'h5;
    localparam logic [15:0] BT_LEN_IMM = 16'h0002;
    localparam logic [15:0] BT_LEN_DIR = 16'h0002;
    localparam logic [15:0] BT_LEN_EXT = 16'h0003;
    localparam logic [15:0] BT_LEN_IX0 = 16'h0001;
    localparam logic [15:0] BT_LEN_IX1 = 16'h0002;
    localparam logic [15:0] BT_LEN_IX2 = 16'h0003;
    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        CBE_IDLE = 2'b00,
        CBE_BUSY = 2'b01,
        CBE_DONE = 2'b10
    } cbe_state_t;
endpackage

//--- rtl/cbe_sync.sv
// Two-stage synchroniser for the external interrupt pin.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module cbe_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    // Reset high: the pin idles high when no one drives it low
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- rtl/cbe_cond.sv
// Condition evaluator: pure decode of branch opcode against flags and pin.
// Assumes flags and pin are stable and in the clock domain.
`timescale 1ns/1ps
module cbe_cond (
    input wire logic [7:0] opcode,
    input wire logic [4:0] ccr,
    input wire logic irq_pin,
    output logic is_branch,
    output logic take
);
    import cbe_pkg::*;
    wire logic h = ccr[CC_H];
    wire logic i = ccr[CC_I];
    wire logic n = ccr[CC_N];
    wire logic z = ccr[CC_Z];
    wire logic c = ccr[CC_C];
    // Opcode pairs differ only in bit 0, which inverts the test
    always_comb begin
        is_branch = 1'b1;
        take = 1'b0;
        case (opcode)
            OP_BRANCH_HALFCARRY_CLEAR: take = ~h;
            OP_BRANCH_HALFCARRY_SET: take = h;
            OP_BRANCH_UNSIGNED_GREATER: take = ~(c | z);
            OP_BRANCH_UNSIGNED_LE: take = c | z;
            OP_BRANCH_CARRY_CLEAR: take = ~c;
            OP_BRANCH_CARRY_SET: take = c;
            OP_BRANCH_NONZERO: take = ~z;
            OP_BRANCH_NEGATIVE: take = n;
            OP_BRANCH_MASK_CLEAR: take = ~i;
            OP_BRANCH_MASK_SET: take = i;
            OP_BRANCH_IRQ_PIN_LOW: take = ~irq_pin;
            OP_BRANCH_IRQ_PIN_HIGH: take = irq_pin;
            default: is_branch = 1'b0;
        endcase
    end
endmodule

//--- rtl/cbe_top.sv
// Conditional branch and bit-test executor for an 8-bit core.
// Assumes the core holds inputs steady while start is high and busy is low;
// operand is the offset byte for branches and memory data for bit-test.
`timescale 1ns/1ps
module cbe_top
#(
    parameter bit CMOS = 1'b0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    input wire logic [15:0] pc_in,
    input wire logic [4:0] ccr_in,
    input wire logic [7:0] accumulator_reg,
    input wire logic irq_pin,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic branch_taken,
    output logic [15:0] pc_out,
    output logic [4:0] ccr_out
);
    import cbe_pkg::*;
    // ************************************************************
    // Input conditioning and decode
    // ************************************************************
    logic pin_sync;
    logic is_branch;
    logic take;
    cbe_sync u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in(irq_pin),
        .sync_out(pin_sync)
    );
    cbe_cond u_cond (
        .opcode(opcode),
        .ccr(ccr_in),
        .irq_pin(pin_sync),
        .is_branch(is_branch),
        .take(take)
    );

    function automatic logic [19:0] bt_decode(input logic [7:0] op,
                                              input bit cm);
        // Returns {cycles, length}; zero cycles means not a bit-test
        logic [19:0] r;
        r = 20'h00000;
        case (op)
            OP_BITTEST_IMM: r = {cm ? CYC_BT_CMOS_IMM : CYC_BT_HMOS_IMM,
                                 BT_LEN_IMM};
            OP_BITTEST_DIR: r = {cm ? CYC_BT_CMOS_DIR : CYC_BT_HMOS_DIR,
                                 BT_LEN_DIR};
            OP_BITTEST_EXT: r = {cm ? CYC_BT_CMOS_EXT : CYC_BT_HMOS_EXT,
                                 BT_LEN_EXT};
            OP_BITTEST_IX0: r = {cm ? CYC_BT_CMOS_IX0 : CYC_BT_HMOS_IX0,
                                 BT_LEN_IX0};
            OP_BITTEST_IX1: r = {cm ? CYC_BT_CMOS_IX1 : CYC_BT_HMOS_IX1,
                                 BT_LEN_IX1};
            OP_BITTEST_IX2: r = {cm ? CYC_BT_CMOS_IX2 : CYC_BT_HMOS_IX2,
                                 BT_LEN_IX2};
            default: r = 20'h00000;
        endcase
        return r;
    endfunction

    wire logic [19:0] bt_info = bt_decode(opcode, CMOS);
    wire logic is_bittest = bt_info[19:16] != 4'h0;
    wire logic [15:0] bt_len = bt_info[15:0];
    wire logic [3:0] bt_cyc = bt_info[19:16];
    wire logic [3:0] br_cyc = CMOS ? CYC_BR_CMOS : CYC_BR_HMOS;
    // Sign extension of the offset byte
    wire logic [15:0] rel_off = {{8{operand[7]}}, operand};
    wire logic [15:0] pc_next = pc_in + BRANCH_LEN;
    wire logic [15:0] br_target = take ? pc_next + rel_off
                                       : pc_next;
    // AND result is never stored anywhere, only inspected
    wire logic [7:0] and_res = accumulator_reg & operand;
    logic [4:0] bt_ccr;
    always_comb begin
        bt_ccr = ccr_in;
        bt_ccr[CC_N] = and_res[7];
        bt_ccr[CC_Z] = and_res == 8'h00;
    end
    wire logic [3:0] sel_cyc = is_branch ? br_cyc : bt_cyc;
    wire logic accept = start & ~busy;
    wire logic known = is_branch | is_bittest;

    // ************************************************************
    // Sequencer
    // ************************************************************
    cbe_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            CBE_IDLE: begin
                if (accept && known) begin
                    state_d = (sel_cyc == 4'h2) ? CBE_DONE : CBE_BUSY;
                    cnt_d = sel_cyc - 4'h3;
                end
            end
            CBE_BUSY: begin
                if (cnt_q == 4'h0) begin
                    state_d = CBE_DONE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            CBE_DONE: state_d = CBE_IDLE;
            default: state_d = CBE_IDLE;
        endcase
    end
    // Done leads the fall of busy by one edge, so the next start is
    // taken exactly N edges after the last one
    wire logic busy_d = state_d != CBE_IDLE;
    wire logic done_d = state_d == CBE_DONE;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= CBE_IDLE;
            cnt_q <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy <= busy_d;
            done <= done_d;
        end
    end
    // ************************************************************
    // Result registers, latched at acceptance
    // ************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pc_out <= 16'h0000;
            ccr_out <= CC_RESET;
            branch_taken <= 1'b0;
            illegal <= 1'b0;
        end else begin
            illegal <= accept & ~known;
            if (accept && is_branch) begin
                pc_out <= br_target;
                ccr_out <= ccr_in;
                branch_taken <= take;
            end else if (accept && is_bittest) begin
                pc_out <= pc_in + bt_len;
                ccr_out <= bt_ccr;
                branch_taken <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Expected values use the inputs sampled at the accept edge
    a_br_keeps_flags: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch |=> ccr_out == $past(ccr_in))
        else $error("branch altered flags");
    a_br_target: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch && take |=> pc_out == $past(pc_in) +
        16'h0002 + {{8{$past(operand[7])}}, $past(operand)})
        else $error("wrong branch target");
    a_br_fall: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch && !take |=> pc_out == $past(pc_in) + 16'h0002)
        else $error("wrong fall-through");
    a_br_latency: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch && !CMOS |=> !done ##1 !done ##1 done)
        else $error("branch latency wrong");
    a_bt_flags: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_bittest |=>
        ccr_out[CC_N] == $past(accumulator_reg[7] & operand[7]) &&
        ccr_out[CC_Z] == ($past(accumulator_reg & operand) == 8'h00))
        else $error("bit-test N or Z wrong");
    a_bt_keeps_hic: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_bittest |=>
        ccr_out[CC_H] == $past(ccr_in[CC_H]) &&
        ccr_out[CC_I] == $past(ccr_in[CC_I]) &&
        ccr_out[CC_C] == $past(ccr_in[CC_C]))
        else $error("bit-test altered H, I or C");
    a_hc_clear: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_HALFCARRY_CLEAR |=>
        branch_taken == !$past(ccr_in[CC_H]))
        else $error("half-carry clear branch wrong");
    a_hc_set: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_HALFCARRY_SET |=>
        branch_taken == $past(ccr_in[CC_H]))
        else $error("half-carry set branch wrong");
    a_ugt_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_UNSIGNED_GREATER |=>
        branch_taken == !($past(ccr_in[CC_C]) | $past(ccr_in[CC_Z])))
        else $error("unsigned greater branch wrong");
    a_uge_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_CARRY_CLEAR |=>
        branch_taken == !$past(ccr_in[CC_C]))
        else $error("carry clear branch wrong");
    a_ult_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_CARRY_SET |=>
        branch_taken == $past(ccr_in[CC_C]))
        else $error("carry set branch wrong");
    a_ule_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_UNSIGNED_LE |=>
        branch_taken == ($past(ccr_in[CC_C]) | $past(ccr_in[CC_Z])))
        else $error("unsigned lower or same branch wrong");
    a_ne_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_NONZERO |=>
        branch_taken == !$past(ccr_in[CC_Z]))
        else $error("not equal branch wrong");
    a_neg_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_NEGATIVE |=>
        branch_taken == $past(ccr_in[CC_N]))
        else $error("negative branch wrong");
    a_pin_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_IRQ_PIN_HIGH |=>
        branch_taken == $past(pin_sync))
        else $error("pin high branch wrong");
    a_pin_low: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_IRQ_PIN_LOW |=>
        branch_taken == !$past(pin_sync))
        else $error("pin low branch wrong");
    a_mask_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_MASK_SET |=>
        branch_taken == $past(ccr_in[CC_I]))
        else $error("mask set branch wrong");
    a_mclr_test: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BRANCH_MASK_CLEAR |=>
        branch_taken == !$past(ccr_in[CC_I]))
        else $error("mask clear branch wrong");
    a_off_positive: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch && take && !operand[7] |=>
        pc_out == $past(pc_in) + 16'h0002 + {8'h00, $past(operand)})
        else $error("forward offset wrong");
    a_off_negative: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_branch && take && operand[7] |=>
        pc_out == $past(pc_in) + 16'h0002 +
        {8'h00, $past(operand)} - 16'h0100)
        else $error("backward offset wrong");
    a_bt_imm_done: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BITTEST_IMM |=> done && busy)
        else $error("immediate bit-test latency wrong");
    a_bt_ext_len: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && opcode == OP_BITTEST_EXT |=>
        pc_out == $past(pc_in) + 16'h0003)
        else $error("extended bit-test length wrong");
    a_bt_no_take: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && is_bittest |=> !branch_taken)
        else $error("bit-test reported a branch");
    a_results_stand: assert property (
        @(posedge clock) disable iff (sys_rst)
        !(accept && known) |=> $stable(pc_out) &&
        $stable(ccr_out) && $stable(branch_taken))
        else $error("result changed without an instruction");
    a_done_pulse: assert property (
        @(posedge clock) disable iff (sys_rst)
        done |=> !done && !busy)
        else $error("done longer than one cycle");
    a_illegal_idle: assert property (
        @(posedge clock) disable iff (sys_rst)
        accept && !known |=> illegal && !busy)
        else $error("unknown opcode not refused");

    c_taken: cover property (@(posedge clock) accept && is_branch && take);
    c_untaken: cover property (@(posedge clock) accept && is_branch && !take);
    c_bittest: cover property (@(posedge clock) accept && is_bittest);
    c_back_to_back: cover property (@(posedge clock) done ##1 accept);
    c_illegal: cover property (@(posedge clock) accept && !known);
endmodule

//--- verif/cbe_partner.sv
// Far-side model: the external interrupt pin seen by the executor.
// Assumes the bench names the wanted level; the pin follows it a little
// after a rising edge, as a source unrelated to the core would.
`timescale 1ns/1ps
module cbe_partner (
    input wire logic clock,
    input wire logic level,
    output logic irq_pin
);
    // Idles high, like an undriven interrupt line with its pull-up
    initial irq_pin = 1'b1;
    always @(posedge clock) begin
        irq_pin <= #1 level;
    end
endmodule

//--- verif/tb_conditional_branch_eval.sv
// Self-checking bench for the branch and bit-test executor.
// Assumes HMOS cycle counts (CMOS = 0) and the partner pin model.
`timescale 1ns/1ps
module tb_conditional_branch_eval;
    import cbe_pkg::*;
    logic clock, sys_rst, start, irq_pin, pin_level;
    logic [7:0] opcode, operand, accumulator_reg;
    logic [15:0] pc_in, pc_out;
    logic [4:0] ccr_in, ccr_out;
    logic busy, done, illegal, branch_taken;
    int error_cnt = 0;
    int checks_done = 0;
    cbe_top #(.CMOS(1'b0)) DUT (.clock(clock), .sys_rst(sys_rst),
        .start(start), .opcode(opcode), .operand(operand), .pc_in(pc_in),
        .ccr_in(ccr_in), .accumulator_reg(accumulator_reg),
        .irq_pin(irq_pin), .busy(busy), .done(done), .illegal(illegal),
        .branch_taken(branch_taken), .pc_out(pc_out), .ccr_out(ccr_out));
    cbe_partner far_end (.clock(clock), .level(pin_level),
        .irq_pin(irq_pin));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Counts falling edges after the accept edge until done shows
    task automatic wait_done(output int cyc);
        cyc = 1;
        while (done !== 1'b1 && cyc < 20) begin
            @(negedge clock);
            cyc++;
        end
        if (done !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic issue(input logic [7:0] op, input logic [7:0] opd,
            output int cyc);
        @(negedge clock);
        opcode = op;
        operand = opd;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        wait_done(cyc);
    endtask
    // Done is a single pulse and busy falls right after it
    task automatic idle_check;
        @(negedge clock);
        check(busy, 1'b0);
        check(done, 1'b0);
    endtask
    function automatic logic take_exp(input logic [7:0] op,
            input logic [4:0] f, input logic p);
        case (op)
            8'h28: take_exp = !f[CC_H];
            8'h29: take_exp = f[CC_H];
            8'h22: take_exp = !(f[CC_C] | f[CC_Z]);
            8'h23: take_exp = f[CC_C] | f[CC_Z];
            8'h24: take_exp = !f[CC_C];
            8'h25: take_exp = f[CC_C];
            8'h26: take_exp = !f[CC_Z];
            8'h2B: take_exp = f[CC_N];
            8'h2C: take_exp = !f[CC_I];
            8'h2D: take_exp = f[CC_I];
            8'h2E: take_exp = !p;
            default: take_exp = p;
        endcase
    endfunction
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Every branch against flag sets and both pin levels, offsets at
    // both ends of the signed range and targets wrapping past FFFF
    task automatic t_branches;
        logic [7:0] ops[12] = '{8'h28, 8'h29, 8'h22, 8'h23, 8'h24, 8'h25,
            8'h26, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
        logic [4:0] flags[6] = '{5'h00, 5'h1F, 5'h01, 5'h02, 5'h14, 5'h08};
        logic [7:0] offs[3] = '{8'h7F, 8'h80, 8'h00};
        logic [7:0] o;
        logic t;
        int cyc;
        for (int p = 0; p < 2; p++) begin
            pin_level = p[0];
            repeat (4) @(negedge clock);
            foreach (ops[i]) begin
                foreach (flags[j]) begin
                    o = offs[j % 3];
                    t = take_exp(ops[i], flags[j], p[0]);
                    pc_in = 16'hFFFE - 16'(j);
                    ccr_in = flags[j];
                    issue(ops[i], o, cyc);
                    check(branch_taken, t);
                    check(pc_out, 16'(t ? pc_in + 16'h0002 + {{8{o[7]}}, o}
                        : pc_in + 16'h0002));
                    check(ccr_out, flags[j]);
                    check(cyc, 3);
                    idle_check();
                end
            end
        end
        $display("test branches finished");
    endtask
    // All six bit-test forms; flags H, I, C must pass through
    task automatic t_bittest;
        logic [7:0] ops[6] = '{8'hA5, 8'hB5, 8'hC5, 8'hF5, 8'hE5, 8'hD5};
        logic [15:0] lens[6] = '{16'h0002, 16'h0002, 16'h0003, 16'h0001,
            16'h0002, 16'h0003};
        int cycs[6] = '{2, 4, 5, 4, 5, 6};
        logic [7:0] accs[3] = '{8'hF0, 8'h80, 8'h5A};
        logic [7:0] mems[3] = '{8'h0F, 8'hFF, 8'h42};
        logic [7:0] r;
        logic [4:0] f;
        int cyc;
        foreach (ops[i]) begin
            for (int k = 0; k < 3; k++) begin
                f = 5'(i * 5 + k * 11);
                r = accs[k] & mems[k];
                pc_in = 16'h1234;
                ccr_in = f;
                accumulator_reg = accs[k];
                issue(ops[i], mems[k], cyc);
                check(ccr_out, {f[4:3], r[7], r == 8'h00, f[0]});
                check(pc_out, 16'(pc_in + lens[i]));
                check(cyc, cycs[i] - 1);
                idle_check();
            end
        end
        $display("test bit-test finished");
    endtask
    // Unknown opcode, then a start held high while busy
    task automatic t_refuse;
        logic [15:0] keep;
        int cyc;
        keep = pc_out;
        @(negedge clock);
        opcode = 8'h20;
        start = 1'b1;
        @(negedge clock);
        // Start stays high: the branch request follows at once
        check(illegal, 1'b1);
        check(busy, 1'b0);
        check(pc_out, keep);
        pc_in = 16'h0100;
        ccr_in = 5'h00;
        opcode = OP_BRANCH_NONZERO;
        operand = 8'h10;
        start = 1'b1;
        @(negedge clock);
        pc_in = 16'h0500;
        @(negedge clock);
        start = 1'b0;
        wait_done(cyc);
        check(pc_out, 16'h0112);
        check(cyc, 2);
        idle_check();
        $display("test refusal finished");
    endtask
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        opcode = 8'h00;
        operand = 8'h00;
        pc_in = 16'h0000;
        ccr_in = 5'h00;
        accumulator_reg = 8'h00;
        pin_level = 1'b1;
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        check(pc_out, 16'h0000);
        check(ccr_out, CC_RESET);
        check(busy, 1'b0);
        t_branches();
        t_bittest();
        t_refuse();
        complete_run();
    end
endmodule
